// ---- rtl/and_and_carry_branch_exec.sv ----
// Notes on behaviour
// - AND of W and file byte; N,Z only
// - d=0 result to W, d=1 to file
// - a=0 access bank, a=1 bank pointer
// - Extended set, a=0, f<=5Fh: indexed offset
// - Carry branch taken only if C; flags kept
// - Target is PC+2+2n, n signed 8-bit
// - Taken branch two cycles, second a nop
`timescale 1ns/100ps
`include "exec_consts.svh"
module and_and_carry_branch_exec
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [20:0] pcIn,
    input wire logic [3:0] bankPointerRegister,
    input wire logic [11:0] indexBase,
    input wire logic extendedSet,
    input wire logic carryIn,
    input wire logic negIn,
    input wire logic zeroIn,
    output logic [7:0] workReg,
    output logic negFlag,
    output logic zeroFlag,
    output logic carryFlag,
    output logic [20:0] pcOut,
    output logic pcLoad,
    output logic instrDone,
    output logic busy
);
    typedef struct packed {
        phase_t phase;
        op_t op;
        logic [15:0] ir;
        logic [20:0] pcBase;
        logic [11:0] addr;
        logic [7:0] result;
        logic nopCycle;
        logic [7:0] w;
        logic n;
        logic z;
        logic c;
        logic [20:0] pcOut;
        logic pcLoad;
        logic done;
        logic busy;
        logic rdEn;
        logic wrEn;
        logic [7:0] wrData;
    } state_t;

    state_t st, next_st;
    file_bus_if fbus();

    file_ram u_ram (
        .clk(clk),
        .bus(fbus.mem)
    );

    assign fbus.rdEn = st.rdEn;
    assign fbus.wrEn = st.wrEn;
    assign fbus.addr = st.addr;
    assign fbus.wrData = st.wrData;

    // Access bank splits at 60h: low part from bank 0, high part from bank 15
    function automatic logic [11:0] file_address(input logic [7:0] f, input logic a,
            input logic ext, input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] r;
        r = {bank, f};
        if (!a) begin
            if (ext && f <= `ILO_LIMIT) begin
                r = base + {4'h0, f};
            end else if (f < `ACCESS_SPLIT) begin
                r = {4'h0, f};
            end else begin
                r = {`ACCESS_HIGH_BANK, f};
            end
        end
        return r;
    endfunction

    // Offset is doubled and sign-extended to the full program counter width
    function automatic logic [20:0] branch_target(input logic [20:0] pc, input logic [7:0] n);
        logic [20:0] off;
        off = {{12{n[7]}}, n, 1'b0};
        return 21'(pc + 21'h2 + off);
    endfunction

    always_comb begin
        next_st = st;
        next_st.pcLoad = 1'b0;
        next_st.done = 1'b0;
        next_st.rdEn = 1'b0;
        next_st.wrEn = 1'b0;
        next_st.phase = phase_t'(st.phase + 2'b01);
        case (st.phase)
            Q1: begin
                next_st.op = OP_NONE;
                next_st.busy = 1'b0;
                // The second cycle of a taken branch refuses any new word
                if (st.nopCycle) begin
                    next_st.busy = 1'b1;
                end else if (instrValid) begin
                    next_st.ir = instrWord;
                    next_st.pcBase = pcIn;
                    next_st.busy = 1'b1;
                    if (instrWord[15:10] == `OPC_AND_FILE_HI) begin
                        next_st.op = OP_AND;
                        next_st.addr = file_address(instrWord[7:0], instrWord[8],
                            extendedSet, bankPointerRegister, indexBase);
                        next_st.rdEn = 1'b1;
                    end else if (instrWord[15:8] == `OPC_BRC_HI) begin
                        next_st.op = OP_BRC;
                    end
                end
            end
            Q2: begin
                next_st.c = carryIn;
                next_st.n = negIn;
                next_st.z = zeroIn;
            end
            Q3: begin
                if (st.op == OP_AND) begin
                    next_st.result = st.w & fbus.rdData;
                end
            end
            Q4: begin
                next_st.nopCycle = 1'b0;
                next_st.done = st.busy && !st.nopCycle;
                if (st.nopCycle) begin
                    next_st.done = 1'b1;
                end
                if (st.op == OP_AND) begin
                    next_st.n = st.result[7];
                    next_st.z = (st.result == 8'h00);
                    // A file write lands in the memory on the next Q1 edge
                    if (st.ir[9]) begin
                        next_st.wrEn = 1'b1;
                        next_st.wrData = st.result;
                    end else begin
                        next_st.w = st.result;
                    end
                end else if (st.op == OP_BRC && st.c) begin
                    next_st.pcOut = branch_target(st.pcBase, st.ir[7:0]);
                    next_st.pcLoad = 1'b1;
                    next_st.nopCycle = 1'b1;
                    next_st.done = 1'b0;
                end
            end
            default: begin
                next_st.phase = Q1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.w <= `W_RESET;
            st.pcOut <= `PC_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign workReg = st.w;
    assign negFlag = st.n;
    assign zeroFlag = st.z;
    assign carryFlag = st.c;
    assign pcOut = st.pcOut;
    assign pcLoad = st.pcLoad;
    assign instrDone = st.done;
    assign busy = st.busy;

    // Checks on the core's own sequencing, sampled on every quarter edge
    a_and_result: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_AND && !st.ir[9]) |=> (workReg == $past(st.result)
        && zeroFlag == ($past(st.result) == 8'h00)))
        else $error("and result or zero flag wrong");
    a_and_sign: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_AND) |=> (negFlag == st.result[7] && !pcLoad))
        else $error("and sign flag wrong");
    a_and_dest: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_AND && st.ir[9]) |=> (fbus.wrEn
        && $stable(workReg)))
        else $error("file destination not written");
    a_file_write: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_AND && st.ir[9]) |=> (fbus.wrData == $past(st.result)
        && fbus.addr == $past(st.addr)))
        else $error("file write data or address wrong");
    a_bank_select: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q1 && !st.nopCycle && instrValid && instrWord[15:10] == `OPC_AND_FILE_HI
        && instrWord[8]) |=> (fbus.addr == {$past(bankPointerRegister),
        $past(instrWord[7:0])}))
        else $error("bank pointer address wrong");
    a_indexed_mode: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q1 && !st.nopCycle && instrValid && instrWord[15:10] == `OPC_AND_FILE_HI
        && !instrWord[8] && extendedSet && instrWord[7:0] <= `ILO_LIMIT)
        |=> (fbus.addr == 12'($past(indexBase) + $past(instrWord[7:0]))))
        else $error("indexed offset address wrong");
    a_branch_flags: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_BRC) |=> (pcLoad == $past(st.c)
        && $stable(negFlag) && $stable(zeroFlag)))
        else $error("carry branch decision or flags wrong");
    a_branch_target: assert property (@(posedge clk) disable iff (sys_rst)
        pcLoad |-> (pcOut == 21'($past(st.pcBase, 1) + 21'h2
        + {{12{st.ir[7]}}, st.ir[7:0], 1'b0})))
        else $error("branch target wrong");
    sequence s_nop_cycle;
        !instrDone [*4] ##1 instrDone;
    endsequence
    sequence s_one_done;
        instrDone && !pcLoad;
    endsequence
    a_taken_two: assert property (@(posedge clk) disable iff (sys_rst)
        pcLoad |-> s_nop_cycle)
        else $error("taken branch not two cycles");
    a_untaken_one: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q4 && st.op == OP_BRC && !st.c) |=> s_one_done)
        else $error("untaken branch not one cycle");
    a_nop_refused: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q1 && st.nopCycle) |=> (!fbus.rdEn && !instrDone && busy))
        else $error("word accepted in nop cycle");
    a_and_quarters: assert property (@(posedge clk) disable iff (sys_rst)
        (st.phase == Q1 && !st.nopCycle && instrValid && instrWord[15:10] == `OPC_AND_FILE_HI)
        |=> fbus.rdEn ##3 instrDone)
        else $error("and not one cycle");
endmodule

// ---- common/exec_consts.svh ----
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define OPC_AND_FILE_HI 6'h05
`define OPC_BRC_HI 8'hE2
`define ILO_LIMIT 8'h5F
`define FSR2_BASE_RESET 12'h000
`define PC_RESET 21'h000000
`define W_RESET 8'h00
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 4'hF
`endif

// ---- common/exec_pkg.sv ----
package exec_pkg;
    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } phase_t;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_AND = 2'b01,
        OP_BRC = 2'b10
    } op_t;
endpackage

// ---- common/file_bus_if.sv ----
`timescale 1ns/100ps
interface file_bus_if;
    logic rdEn;
    logic wrEn;
    logic [11:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport core (output rdEn, output wrEn, output addr, output wrData, input rdData);
    modport mem (input rdEn, input wrEn, input addr, input wrData, output rdData);
endinterface

// ---- rtl/file_ram.sv ----
`timescale 1ns/100ps
module file_ram #(
    parameter int DEPTH = 4096
) (
    input wire logic clk,
    file_bus_if.mem bus
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdReg;
    always_ff @(posedge clk) begin
        if (bus.wrEn) begin
            mem[bus.addr] <= bus.wrData;
        end
        if (bus.rdEn) begin
            rdReg <= mem[bus.addr];
        end
    end
    assign bus.rdData = rdReg;
endmodule

// ---- dv/test_and_and_carry_branch_exec.sv ----
`timescale 1ns/100ps
module test_and_and_carry_branch_exec;
    import exec_pkg::*;
    // fl holds extendedSet, carryIn, negIn, zeroIn; nz is the expected {negFlag, zeroFlag}
    typedef struct {
        logic [15:0] word;
        logic [20:0] pc;
        logic [3:0] fl;
        int lat;
        logic load;
        logic [20:0] target;
        logic [1:0] nz;
    } row_t;
    row_t rows[8] = '{
        '{16'h1410, 21'h000100, 4'h6, 4, 1'b0, 21'h000000, 2'h1},
        '{16'h17FF, 21'h000100, 4'h3, 4, 1'b0, 21'h000000, 2'h1},
        '{16'h145F, 21'h000100, 4'hC, 4, 1'b0, 21'h000000, 2'h1},
        '{16'hE205, 21'h000100, 4'h7, 8, 1'b1, 21'h00010C, 2'h3},
        '{16'hE280, 21'h001000, 4'h4, 8, 1'b1, 21'h000F02, 2'h0},
        '{16'hE27F, 21'h1FFFFE, 4'hE, 8, 1'b1, 21'h0000FE, 2'h2},
        '{16'hE205, 21'h000200, 4'h3, 4, 1'b0, 21'h000000, 2'h3},
        '{16'hE605, 21'h000300, 4'h5, 4, 1'b0, 21'h000000, 2'h1}};
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic instrValid = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [20:0] pcIn = 21'h000000;
    logic [3:0] bankPointerRegister = 4'h0;
    logic [11:0] indexBase = 12'h080;
    logic extendedSet = 1'b0;
    logic carryIn = 1'b0;
    logic negIn = 1'b0;
    logic zeroIn = 1'b0;
    logic [7:0] workReg;
    logic negFlag, zeroFlag, carryFlag, pcLoad, instrDone, busy;
    logic [20:0] pcOut;
    int mismatches = 0;
    int checksDone = 0;
    int edgeCnt = 0;

    and_and_carry_branch_exec dut (.clk, .sys_rst(sysRst), .instrValid, .instrWord, .pcIn,
        .bankPointerRegister, .indexBase, .extendedSet, .carryIn, .negIn, .zeroIn, .workReg,
        .negFlag, .zeroFlag, .carryFlag, .pcOut, .pcLoad, .instrDone, .busy);

    initial forever #25 clk = ~clk;
    // Edges counted from reset release; a multiple of 4 means the next edge is Q1
    always @(posedge clk) edgeCnt <= sysRst ? 0 : edgeCnt + 1;

    task results;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task check(input string what, input logic [20:0] exp, input logic [20:0] got);
        checksDone++;
        if (got !== exp) begin
            $display("BAD %s expected %0h seen %0h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic start(input row_t r);
        int k;
        for (k = 0; k < 5 && edgeCnt % 4 != 0; k++) @(negedge clk);
        if (edgeCnt % 4 != 0) begin
            mismatches++;
            results();
        end
        {extendedSet, carryIn, negIn, zeroIn} = r.fl;
        instrWord = r.word;
        pcIn = r.pc;
        bankPointerRegister = r.word[11:8];
        instrValid = 1'b1;
    endtask

    task automatic run(input row_t r, output int lat, output int loadAt, output logic [20:0] tgt);
        int k;
        lat = -1;
        loadAt = -1;
        tgt = 21'h000000;
        start(r);
        for (k = 1; k < 13 && lat < 0; k++) begin
            @(negedge clk);
            instrValid = 1'b0;
            if (pcLoad === 1'b1) begin
                loadAt = k;
                tgt = pcOut;
            end
            if (instrDone === 1'b1) lat = k;
        end
        if (lat < 0) begin
            mismatches++;
            results();
        end
    endtask

    initial begin
        int i;
        int n;
        int lat;
        int loadAt;
        logic [20:0] tgt;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("pcLoad", 21'h0, {20'h0, pcLoad});
        check("busy", 21'h0, {20'h0, busy});
        check("workReg", 21'h0, {13'h0, workReg});
        sysRst = 1'b0;
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            run(rows[i], lat, loadAt, tgt);
            check("latency", 21'(rows[i].lat), 21'(lat));
            check("pcLoad", rows[i].load ? 21'h4 : 21'h1FFFFF, 21'(loadAt));
            if (rows[i].load) check("pcOut", rows[i].target, tgt);
            check("flags", {19'h0, rows[i].nz}, {19'h0, negFlag, zeroFlag});
            check("carryFlag", {20'h0, rows[i].fl[2]}, {20'h0, carryFlag});
            check("workReg", 21'h0, {13'h0, workReg});
            check("busy", 21'h1, {20'h0, busy});
            $display("row %0d done", i);
        end
        // An instruction offered in the nop cycle of a taken branch must be dropped
        start('{16'hE202, 21'h000010, 4'h6, 8, 1'b1, 21'h000016, 2'h2});
        n = 0;
        for (i = 1; i < 13; i++) begin
            @(negedge clk);
            instrWord = 16'h1410;
            instrValid = (i == 4);
            if (instrDone === 1'b1) n++;
        end
        check("done pulses", 21'h1, 21'(n));
        check("negFlag", 21'h1, {20'h0, negFlag});
        $display("nop refusal test done");
        start(rows[3]);
        @(negedge clk);
        instrValid = 1'b0;
        sysRst = 1'b1;
        repeat (2) @(negedge clk);
        check("pcLoad", 21'h0, {20'h0, pcLoad});
        check("busy", 21'h0, {20'h0, busy});
        sysRst = 1'b0;
        run(rows[3], lat, loadAt, tgt);
        check("pcOut", rows[3].target, tgt);
        $display("mid-run reset test done");
        results();
    end
endmodule
